/* File: rtl/ipt_pkg.sv */
// Package for the presented-interrupt report and proximity timer block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package ipt_pkg;

  // Register byte offsets
  localparam logic [11:0] REPORT_OFFSET = 12'h000;
  localparam logic [11:0] RELOAD_OFFSET = 12'h004;
  localparam logic [11:0] CTRL_OFFSET   = 12'h008;

  // Report field layout
  localparam int PRIO_LSB = 8;
  localparam int PRIO_MSB = 10;
  localparam int VEC_LSB  = 0;
  localparam int VEC_MSB  = 5;

  // Control register field layout
  localparam int CTRL_SINGLE_BIT = 0;

  // Reset values
  localparam logic [31:0] REPORT_RESET = 32'h0000_0000;
  localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

  // Implemented-bit mask of the report register
  localparam logic [31:0] REPORT_MASK = 32'h0000_073F;

  // Timer states
  typedef enum logic [1:0] {
    IPT_IDLE,
    IPT_COUNT,
    IPT_FIRE
  } ipt_state_t;

endpackage : ipt_pkg

/* File: rtl/ipt_tmr_if.sv */
// Interface between the register file and the proximity timer.
// Assumes both ends run on mclk.
`timescale 1ns/1ns
`default_nettype none
interface ipt_tmr_if;
  logic        trigger;
  logic [31:0] reload;
  logic        busy;
  logic        fire;
  logic [31:0] count;

  modport regs  (output trigger, output reload, input busy, input fire, input count);
  modport timer (input trigger, input reload, output busy, output fire, output count);
endinterface : ipt_tmr_if
`default_nettype wire

/* File: rtl/ipt_timer.sv */
// Proximity timer: reload on trigger, count down, fire at zero.
// Assumes trigger is a one-cycle pulse in the mclk domain.
`timescale 1ns/1ns
`default_nettype none
module ipt_timer (
  input  wire logic mclk,
  input  wire logic rst,
  ipt_tmr_if.timer  tmr
);

  ipt_pkg::ipt_state_t stateR;
  ipt_pkg::ipt_state_t stateNxt;
  logic [31:0]         countR;
  logic [31:0]         countNxt;

  always_comb begin
    stateNxt = stateR;
    countNxt = countR;
    unique case (stateR)
      ipt_pkg::IPT_IDLE: begin
        if (tmr.trigger) begin
          countNxt = tmr.reload;
          stateNxt = (tmr.reload == 32'h0000_0000) ? ipt_pkg::IPT_FIRE : ipt_pkg::IPT_COUNT;
        end
      end
      ipt_pkg::IPT_COUNT: begin
        // Further triggers while held off do not restart the window
        countNxt = countR - 32'h0000_0001;
        if (countR == 32'h0000_0001) begin
          stateNxt = ipt_pkg::IPT_FIRE;
        end
      end
      ipt_pkg::IPT_FIRE: begin
        stateNxt = ipt_pkg::IPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stateR <= ipt_pkg::IPT_IDLE;
      countR <= 32'h0000_0000;
    end else begin
      stateR <= stateNxt;
      countR <= countNxt;
    end
  end

  assign tmr.busy  = (stateR == ipt_pkg::IPT_COUNT);
  assign tmr.fire  = (stateR == ipt_pkg::IPT_FIRE);
  assign tmr.count = countR;

endmodule : ipt_timer
`default_nettype wire

/* File: rtl/ipt_top.sv */
// Presented-interrupt report and proximity timer with APB slave.
// Assumes an APB master on mclk; interrupt requests come from same-clock logic.
// Function
// - Report priority of latest presented interrupt, bits 10:8
// - Report presented vector number in bits 5:0
// - Report meaningful only in single-vector configuration
// - Interrupt event loads timer from reload register
// - Report bits 31:11 and 7:6 read zero
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ipt_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        irqReq,
  input  wire logic [2:0]  irqPriority,
  input  wire logic [5:0]  irqVector,
  output var  logic        coreIrq,
  output var  logic [2:0]  corePriority,
  output var  logic [5:0]  coreVector,
  output var  logic        singleVector
);

  ipt_tmr_if tmr ();

  ipt_timer uTimer (
    .mclk (mclk),
    .rst  (rst),
    .tmr  (tmr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [2:0]  prioR,    prioNxt;
  logic [5:0]  vecR,     vecNxt;
  logic [31:0] reloadR,  reloadNxt;
  logic        singleR,  singleNxt;
  logic        heldR,    heldNxt;
  logic [2:0]  heldPrioR, heldPrioNxt;
  logic [5:0]  heldVecR, heldVecNxt;
  logic        coreIrqR, coreIrqNxt;
  logic [31:0] prdataR,  prdataNxt;
  logic        preadyR,  preadyNxt;
  logic        pslverrR, pslverrNxt;
  logic        trigR,    trigNxt;

  logic        access;
  logic        wrEn;
  logic        mapped;
  logic [31:0] reportView;

  assign access = psel && penable && !preadyR;
  assign wrEn   = access && pwrite;
  assign mapped = (paddr == ipt_pkg::REPORT_OFFSET) ||
                  (paddr == ipt_pkg::RELOAD_OFFSET) ||
                  (paddr == ipt_pkg::CTRL_OFFSET);

  always_comb begin
    reportView = 32'h0000_0000;
    reportView[ipt_pkg::PRIO_MSB:ipt_pkg::PRIO_LSB] = prioR;
    reportView[ipt_pkg::VEC_MSB:ipt_pkg::VEC_LSB]   = vecR;
  end

  assign tmr.trigger = trigR;
  assign tmr.reload  = reloadR;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    prioNxt     = prioR;
    vecNxt      = vecR;
    reloadNxt   = reloadR;
    singleNxt   = singleR;
    heldNxt     = heldR;
    heldPrioNxt = heldPrioR;
    heldVecNxt  = heldVecR;
    coreIrqNxt  = 1'b0;
    trigNxt     = 1'b0;
    prdataNxt   = prdataR;
    preadyNxt   = 1'b0;
    pslverrNxt  = 1'b0;

    // Requests are held off while the timer runs, then the highest-priority one is delivered
    if (irqReq && !heldR) begin
      heldNxt     = 1'b1;
      heldPrioNxt = irqPriority;
      heldVecNxt  = irqVector;
      trigNxt     = !tmr.busy;
    end else if (irqReq && heldR && irqPriority > heldPrioR) begin
      heldPrioNxt = irqPriority;
      heldVecNxt  = irqVector;
    end

    if (tmr.fire && heldR) begin
      coreIrqNxt  = 1'b1;
      heldNxt     = 1'b0;
      // Report only tracks presentations in single-vector configuration
      if (singleR) begin
        prioNxt = heldPrioR;
        vecNxt  = heldVecR;
      end
    end

    if (access) begin
      preadyNxt  = 1'b1;
      pslverrNxt = !mapped;
      if (!pwrite) begin
        unique case (paddr)
          ipt_pkg::REPORT_OFFSET: prdataNxt = reportView & ipt_pkg::REPORT_MASK;
          ipt_pkg::RELOAD_OFFSET: prdataNxt = reloadR;
          ipt_pkg::CTRL_OFFSET:   prdataNxt = {31'h0, singleR};
          default:                prdataNxt = 32'h0000_0000;
        endcase
      end
    end

    // Software writes lose to a presentation in the same cycle
    if (wrEn) begin
      unique case (paddr)
        ipt_pkg::REPORT_OFFSET: begin
          if (!(tmr.fire && heldR && singleR)) begin
            prioNxt = pwdata[ipt_pkg::PRIO_MSB:ipt_pkg::PRIO_LSB];
            vecNxt  = pwdata[ipt_pkg::VEC_MSB:ipt_pkg::VEC_LSB];
          end
        end
        ipt_pkg::RELOAD_OFFSET: reloadNxt = pwdata;
        ipt_pkg::CTRL_OFFSET:   singleNxt = pwdata[ipt_pkg::CTRL_SINGLE_BIT];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (rst) begin
      prioR     <= ipt_pkg::REPORT_RESET[ipt_pkg::PRIO_MSB:ipt_pkg::PRIO_LSB];
      vecR      <= ipt_pkg::REPORT_RESET[ipt_pkg::VEC_MSB:ipt_pkg::VEC_LSB];
      reloadR   <= ipt_pkg::RELOAD_RESET;
      singleR   <= ipt_pkg::CTRL_RESET[ipt_pkg::CTRL_SINGLE_BIT];
      heldR     <= 1'b0;
      heldPrioR <= 3'h0;
      heldVecR  <= 6'h00;
      coreIrqR  <= 1'b0;
      trigR     <= 1'b0;
      prdataR   <= 32'h0000_0000;
      preadyR   <= 1'b0;
      pslverrR  <= 1'b0;
    end else begin
      prioR     <= prioNxt;
      vecR      <= vecNxt;
      reloadR   <= reloadNxt;
      singleR   <= singleNxt;
      heldR     <= heldNxt;
      heldPrioR <= heldPrioNxt;
      heldVecR  <= heldVecNxt;
      coreIrqR  <= coreIrqNxt;
      trigR     <= trigNxt;
      prdataR   <= prdataNxt;
      preadyR   <= preadyNxt;
      pslverrR  <= pslverrNxt;
    end
  end

  assign prdata       = prdataR;
  assign pready       = preadyR;
  assign pslverr      = pslverrR;
  assign coreIrq      = coreIrqR;
  assign corePriority = prioR;
  assign coreVector   = vecR;
  assign singleVector = singleR;

endmodule : ipt_top
`default_nettype wire

/* File: tb/ipt_monitor.sv */
// Checker on the top ports of the report and proximity timer block.
// Assumes one clock, mclk, and a synchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none
module ipt_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irqReq,
  input wire logic        coreIrq,
  input wire logic [2:0]  corePriority,
  input wire logic [5:0]  coreVector,
  input wire logic        singleVector
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic relZero_r;
  logic relZero_nxt;
  wire logic relWr = pready && pwrite && paddr == ipt_pkg::RELOAD_OFFSET;
  wire logic repWr = pready && pwrite && paddr == ipt_pkg::REPORT_OFFSET;
  always_comb relZero_nxt = relWr ? pwdata == 32'h0000_0000 : relZero_r;
  always_ff @(posedge mclk) relZero_r <= rst ? 1'b1 : relZero_nxt;
  //////////////////////////////////////////////////////////////////////////
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready too long");
  property p_err; pready && paddr > ipt_pkg::CTRL_OFFSET |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rsv;
    pready && !pwrite && paddr == 12'h000 |-> (prdata & ~ipt_pkg::REPORT_MASK) == 32'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved report bits set");
  property p_src;
    $changed(coreVector) || $changed(corePriority) |-> coreIrq || repWr;
  endproperty
  a_src: assert property (p_src) else $error("report moved without delivery");
  property p_mv; coreIrq && !singleVector |-> $stable(coreVector); endproperty
  a_mv: assert property (p_mv) else $error("report moved outside single mode");
  property p_pls; coreIrq |=> !coreIrq; endproperty
  a_pls: assert property (p_pls) else $error("delivery not a pulse");
  // Held two edges in the timer path, so the pulse is sampled on the third edge
  property p_ld0; irqReq && !$past(irqReq) && relZero_r |-> ##3 coreIrq; endproperty
  a_ld0: assert property (p_ld0) else $error("zero reload not immediate");
  c_fire: cover property (coreIrq && singleVector);
  c_off: cover property (coreIrq && !singleVector);
  c_err: cover property (pslverr);
endmodule : ipt_monitor
bind ipt_top ipt_monitor u_mon (
  .mclk         (mclk),
  .rst          (rst),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .pwdata       (pwdata),
  .prdata       (prdata),
  .pready       (pready),
  .pslverr      (pslverr),
  .irqReq       (irqReq),
  .coreIrq      (coreIrq),
  .corePriority (corePriority),
  .coreVector   (coreVector),
  .singleVector (singleVector)
);
`default_nettype wire

/* File: tb/ipt_core_model.sv */
// Core-side model: takes each delivered interrupt and keeps its vector.
// Assumes coreIrq is a one-cycle pulse on mclk.
`timescale 1ns/1ns
`default_nettype none
module ipt_core_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       coreIrq,
  input  wire logic [5:0] coreVector,
  output var  logic [7:0] taken,
  output var  logic [5:0] lastVec
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      taken   <= 8'h00;
      lastVec <= 6'h00;
    end else if (coreIrq) begin
      taken   <= taken + 8'h01;
      lastVec <= coreVector;
    end
  end
endmodule : ipt_core_model
`default_nettype wire

/* File: tb/test_irq_status_proximity_timer.sv */
// Bench for the report and proximity timer block over APB.
// Assumes the core model sits on the delivery outputs.
`timescale 1ns/1ns
`default_nettype none
module test_irq_status_proximity_timer;
  logic        mclk, rst, psel, penable, pwrite, irqReq, err;
  logic        pready, pslverr, coreIrq, singleVector;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, old;
  logic [2:0]  irqPriority, corePriority;
  logic [5:0]  irqVector, coreVector, lastVec;
  logic [7:0]  taken;
  int          n_fail, tests_run;
  ipt_top u_dut (
    .mclk         (mclk),
    .rst          (rst),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .irqReq       (irqReq),
    .irqPriority  (irqPriority),
    .irqVector    (irqVector),
    .coreIrq      (coreIrq),
    .corePriority (corePriority),
    .coreVector   (coreVector),
    .singleVector (singleVector)
  );
  ipt_core_model u_core (
    .mclk       (mclk),
    .rst        (rst),
    .coreIrq    (coreIrq),
    .coreVector (coreVector),
    .taken      (taken),
    .lastVec    (lastVec)
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Request stands until the rising edge at which pready is seen high
    for (int i = 0; i <= 50; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
      if (i == 50) begin
        n_fail++;
        conclude();
      end
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Request is a one-cycle pulse so no second window opens
  task automatic fire(logic [2:0] p, logic [5:0] v, logic [31:0] rel, logic sv);
    int n;
    apb(1'b1, ipt_pkg::RELOAD_OFFSET, rel);
    apb(1'b1, ipt_pkg::CTRL_OFFSET, {31'h0, sv});
    apb(1'b0, ipt_pkg::REPORT_OFFSET, 32'h0);
    old = rd;
    @(posedge mclk);
    irqReq      <= 1'b1;
    irqPriority <= p;
    irqVector   <= v;
    @(posedge mclk);
    irqReq <= 1'b0;
    n = 0;
    // Delivery launches two edges after the taking edge plus the reload count
    do begin
      @(posedge mclk);
      n++;
    end while (coreIrq !== 1'b1 && n < 60);
    if (coreIrq !== 1'b1) begin
      n_fail++;
      conclude();
    end
    chk("delay", rel + 32'h3, 32'(n));
    chk("core priority", sv ? {29'h0, p} : {29'h0, old[10:8]}, {29'h0, corePriority});
    chk("single mode", {31'h0, sv}, {31'h0, singleVector});
    apb(1'b0, ipt_pkg::REPORT_OFFSET, 32'h0);
    chk("report", sv ? {21'h0, p, 2'h0, v} : old, rd);
    chk("core vector", sv ? {26'h0, v} : {26'h0, old[5:0]}, {26'h0, lastVec});
  endtask : fire
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, irqReq} = 5'h1F;
    {psel, penable, irqReq} = 3'h0;
    {paddr, pwdata, irqPriority, irqVector} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, ipt_pkg::REPORT_OFFSET, 32'h0);
    chk("report reset", 32'h0000_0000, rd);
    apb(1'b0, ipt_pkg::RELOAD_OFFSET, 32'h0);
    chk("reload reset", 32'h0000_0000, rd);
    chk("mapped no error", 32'h0, {31'h0, err});
    apb(1'b0, ipt_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl reset", 32'h0000_0001, rd);
    apb(1'b1, 12'h00C, 32'h1234_5678);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped read error", 32'h1, {31'h0, err});
    apb(1'b1, ipt_pkg::RELOAD_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, ipt_pkg::RELOAD_OFFSET, 32'h0);
    chk("reload rw", 32'hFFFF_FFFF, rd);
    apb(1'b1, ipt_pkg::REPORT_OFFSET, 32'hFFFF_FFFF);
    apb(1'b0, ipt_pkg::REPORT_OFFSET, 32'h0);
    chk("report mask", 32'h0000_073F, rd);
    fire(3'h5, 6'h2A, 32'h0, 1'b1);
    fire(3'h3, 6'h15, 32'h3, 1'b1);
    fire(3'h7, 6'h3F, 32'h1, 1'b0);
    chk("deliveries", 32'h3, {24'h0, taken});
    conclude();
  end
endmodule : test_irq_status_proximity_timer
`default_nettype wire
